// *** rtl/pwmdb_map.svh ***
`ifndef PWMDB_MAP_SVH
`define PWMDB_MAP_SVH
// register offsets
`define PWMDB_OFS_CTL 8'h00
`define PWMDB_OFS_ENABLE 8'h08
`define PWMDB_OFS_INVERT 8'h0C
`define PWMDB_OFS_FAULT 8'h10
`define PWMDB_OFS_INTEN 8'h14
`define PWMDB_OFS_STATUS 8'h20
`define PWMDB_OFS_LOAD 8'h50
`define PWMDB_OFS_COUNT 8'h54
`define PWMDB_OFS_CMPA 8'h58
`define PWMDB_OFS_CMPB 8'h5C
`define PWMDB_OFS_GENA 8'h60
`define PWMDB_OFS_GENB 8'h64
`define PWMDB_OFS_DBCTL 8'h68
`define PWMDB_OFS_DBRISE 8'h6C
`define PWMDB_OFS_DBFALL 8'h70
// control field positions
`define PWMDB_CTL_RUN 0
`define PWMDB_CTL_UPDOWN 1
`define PWMDB_CTL_SYNCMODE 2
`define PWMDB_CTL_GUPDATE 3
// action field positions within a generator control word
`define PWMDB_GEN_ZERO 0
`define PWMDB_GEN_LOAD 2
`define PWMDB_GEN_AUP 4
`define PWMDB_GEN_ADN 6
`define PWMDB_GEN_BUP 8
`define PWMDB_GEN_BDN 10
// interrupt enable positions, events keep the same order
`define PWMDB_INT_FAULT 6
// reset values
`define PWMDB_RST_WORD16 16'h0000
`define PWMDB_RST_WORD12 12'h000
`define PWMDB_RST_BITS2 2'h0
`define PWMDB_RST_RDATA 32'h0000_0000
`endif

// *** rtl/pwmdb_pkg.sv ***
package pwmdb_pkg;
  typedef logic [7:0] pwmdb_addr_t;
  typedef logic [31:0] pwmdb_data_t;
  typedef enum logic [1:0]
  {
    PWMDB_ACT_KEEP = 2'h0,
    PWMDB_ACT_TOGGLE = 2'h1,
    PWMDB_ACT_LOW = 2'h2,
    PWMDB_ACT_HIGH = 2'h3
  } pwmdb_act_e;
  typedef struct packed {
    logic [15:0] count;
    logic dir;
    logic [15:0] load;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] sh_load;
    logic [15:0] sh_cmpa;
    logic [15:0] sh_cmpb;
    logic pend;
    logic run;
    logic updown;
    logic syncmode;
    logic [11:0] gena;
    logic [11:0] genb;
    logic dben;
    logic [11:0] dbrise;
    logic [11:0] dbfall;
    logic [1:0] enable;
    logic [1:0] invert;
    logic [1:0] faulten;
    logic [6:0] inten;
    logic first_gen_output;
    logic second_gen_output;
    logic da;
    logic db;
    logic [11:0] rcnt;
    logic [11:0] fcnt;
    logic out_a;
    logic out_b;
    logic irq;
    logic [31:0] rd_data;
    logic f_meta;
    logic f_sync;
  } pwmdb_state_s;
endpackage

// *** rtl/pwmdb_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pwmdb_map.svh"

// Notes on behaviour
// - one 16-bit counter; 16-bit load value sets the period.
// - count-down mode runs load to zero, reloads, continues.
// - up/down mode runs zero to load and back, repeating.
// - direction low in count-down; high while incrementing in up/down.
// - one-cycle strobe at counter zero and another at load value.
// - in count-down the load strobe follows the zero strobe.
// - comparators A and B strobe when their value equals the counter.
// - in up/down mode matches split into up and down events.
// - a compare value above the load value never matches.
// - four events in count-down, six in up/down.
// - matches coinciding with zero or load are ignored.
// - on coinciding matches, output one uses A, output two uses B.
// - each event applies keep, toggle, low or high per output.
// - dead-band disabled passes both generated signals unchanged.
// - dead-band enabled drops signal two; output one delays rising edge.
// - dead-band output two is inverted input, rising edge delayed.
// - any subset of events can be enabled to raise the interrupt.
// - interrupt uses raw events, not dead-band delayed edges.
// - each output has its own enable to the pin.
// - each output has optional inversion and fault handling.
// - one hardware fault input forces fast output shutdown.
// - load and compare updates take effect synchronised, not mid-period.
// - immediate mode applies a new value at the next counter zero.
// - synchronous mode waits for global update, then next zero.
// - fault with fault enable forces output inactive; may interrupt.
// - outputs active high; inversion makes an output active low.
module pwmdb_gen
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire pwmdb_pkg::pwmdb_addr_t addr,
  input wire pwmdb_pkg::pwmdb_data_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output var pwmdb_pkg::pwmdb_data_t rd_data,
  input wire logic fault_in,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic irq
);
  import pwmdb_pkg::*;

  pwmdb_state_s q;
  pwmdb_state_s next_q;

  logic ev_zero;
  logic ev_load;
  logic match_a;
  logic match_b;
  logic ev_aup;
  logic ev_adn;
  logic ev_bup;
  logic ev_bdn;
  logic pre_a;
  logic pre_b;
  logic [5:0] ev_vec;

  function automatic logic apply_act(input logic cur, input logic [1:0] code);
    case (pwmdb_act_e'(code))
      PWMDB_ACT_KEEP: apply_act = cur;
      PWMDB_ACT_TOGGLE: apply_act = ~cur;
      PWMDB_ACT_LOW: apply_act = 1'b0;
      PWMDB_ACT_HIGH: apply_act = 1'b1;
      default: apply_act = cur;
    endcase
  endfunction

  // one generated signal; own_a selects which comparator wins a tie
  function automatic logic gen_step(input logic cur, input logic [11:0] gen,
                                    input logic own_a, input logic [5:0] ev);
    logic n;
    n = cur;
    if (ev[0])
      n = apply_act(n, gen[`PWMDB_GEN_ZERO +: 2]);
    if (ev[1])
      n = apply_act(n, gen[`PWMDB_GEN_LOAD +: 2]);
    if (own_a && (ev[2] || ev[3]))
    begin
      n = ev[2] ? apply_act(n, gen[`PWMDB_GEN_AUP +: 2]) : apply_act(n, gen[`PWMDB_GEN_ADN +: 2]);
    end
    else if (!own_a && (ev[4] || ev[5]))
    begin
      n = ev[4] ? apply_act(n, gen[`PWMDB_GEN_BUP +: 2]) : apply_act(n, gen[`PWMDB_GEN_BDN +: 2]);
    end
    else if (ev[2] || ev[3])
    begin
      n = ev[2] ? apply_act(n, gen[`PWMDB_GEN_AUP +: 2]) : apply_act(n, gen[`PWMDB_GEN_ADN +: 2]);
    end
    else if (ev[4] || ev[5])
    begin
      n = ev[4] ? apply_act(n, gen[`PWMDB_GEN_BUP +: 2]) : apply_act(n, gen[`PWMDB_GEN_BDN +: 2]);
    end
    gen_step = n;
  endfunction

  // pin stage: enable, fault force to inactive, polarity
  function automatic logic pin_stage(input logic sig, input logic en, input logic fen,
                                     input logic flt, input logic inv);
    pin_stage = en ? (((fen && flt) ? 1'b0 : sig) ^ inv) : 1'b0;
  endfunction

  // raw counter and comparator events
  always_comb
  begin
    ev_zero = q.run && (q.count == 16'h0000);
    ev_load = q.run && (q.count == q.load);
    match_a = q.run && (q.cmpa <= q.load) && (q.count == q.cmpa);
    match_b = q.run && (q.cmpb <= q.load) && (q.count == q.cmpb);
    ev_aup = match_a && q.updown && q.dir && !ev_zero && !ev_load;
    ev_adn = match_a && !(q.updown && q.dir) && !ev_zero && !ev_load;
    ev_bup = match_b && q.updown && q.dir && !ev_zero && !ev_load;
    ev_bdn = match_b && !(q.updown && q.dir) && !ev_zero && !ev_load;
    ev_vec = {ev_bdn, ev_bup, ev_adn, ev_aup, ev_load, ev_zero};
    pre_a = q.dben ? q.da : q.first_gen_output;
    pre_b = q.dben ? q.db : q.second_gen_output;
  end

  always_comb
  begin
    logic gupd;
    logic wsel;
    gupd = 1'b0;
    wsel = 1'b0;
    next_q = q;
    next_q.rd_data = `PWMDB_RST_RDATA;
    // fault pin synchroniser
    next_q.f_meta = fault_in;
    next_q.f_sync = q.f_meta;
    // register writes
    if (wr_en)
    begin
      case (addr)
        `PWMDB_OFS_CTL:
        begin
          next_q.run = wr_data[`PWMDB_CTL_RUN];
          next_q.updown = wr_data[`PWMDB_CTL_UPDOWN];
          next_q.syncmode = wr_data[`PWMDB_CTL_SYNCMODE];
          gupd = wr_data[`PWMDB_CTL_GUPDATE];
        end
        `PWMDB_OFS_ENABLE: next_q.enable = wr_data[1:0];
        `PWMDB_OFS_INVERT: next_q.invert = wr_data[1:0];
        `PWMDB_OFS_FAULT: next_q.faulten = wr_data[1:0];
        `PWMDB_OFS_INTEN: next_q.inten = wr_data[6:0];
        `PWMDB_OFS_LOAD:
        begin
          next_q.sh_load = wr_data[15:0];
          wsel = 1'b1;
        end
        `PWMDB_OFS_CMPA:
        begin
          next_q.sh_cmpa = wr_data[15:0];
          wsel = 1'b1;
        end
        `PWMDB_OFS_CMPB:
        begin
          next_q.sh_cmpb = wr_data[15:0];
          wsel = 1'b1;
        end
        `PWMDB_OFS_GENA: next_q.gena = wr_data[11:0];
        `PWMDB_OFS_GENB: next_q.genb = wr_data[11:0];
        `PWMDB_OFS_DBCTL: next_q.dben = wr_data[0];
        `PWMDB_OFS_DBRISE: next_q.dbrise = wr_data[11:0];
        `PWMDB_OFS_DBFALL: next_q.dbfall = wr_data[11:0];
        default: next_q.rd_data = `PWMDB_RST_RDATA;
      endcase
    end
    // shadow values go live only at counter zero
    if (q.pend && (q.count == 16'h0000))
    begin
      next_q.load = q.sh_load;
      next_q.cmpa = q.sh_cmpa;
      next_q.cmpb = q.sh_cmpb;
      next_q.pend = 1'b0;
    end
    if ((wsel && !q.syncmode) || gupd)
      next_q.pend = 1'b1;
    // counter
    if (!q.run)
    begin
      next_q.count = 16'h0000;
      next_q.dir = 1'b0;
    end
    else if (!q.updown)
    begin
      next_q.dir = 1'b0;
      next_q.count = (q.count == 16'h0000) ? next_q.load : q.count - 16'h0001;
    end
    else if (q.dir)
    begin
      if (q.count >= next_q.load)
      begin
        next_q.dir = 1'b0;
        next_q.count = (q.count == 16'h0000) ? 16'h0000 : q.count - 16'h0001;
      end
      else
        next_q.count = q.count + 16'h0001;
    end
    else if (q.count == 16'h0000)
    begin
      next_q.dir = 1'b1;
      next_q.count = (next_q.load == 16'h0000) ? 16'h0000 : 16'h0001;
    end
    else
      next_q.count = q.count - 16'h0001;
    // generated signals
    next_q.first_gen_output = gen_step(q.first_gen_output, q.gena, 1'b1, ev_vec);
    next_q.second_gen_output = gen_step(q.second_gen_output, q.genb, 1'b0, ev_vec);
    // dead-band: delayed rise of signal one, delayed rise of its inverse
    if (!q.first_gen_output)
    begin
      next_q.da = 1'b0;
      next_q.rcnt = `PWMDB_RST_WORD12;
    end
    else if (!q.da)
    begin
      if (q.rcnt >= q.dbrise)
        next_q.da = 1'b1;
      else
        next_q.rcnt = q.rcnt + 12'h001;
    end
    if (q.first_gen_output)
    begin
      next_q.db = 1'b0;
      next_q.fcnt = `PWMDB_RST_WORD12;
    end
    else if (!q.db)
    begin
      if (q.fcnt >= q.dbfall)
        next_q.db = 1'b1;
      else
        next_q.fcnt = q.fcnt + 12'h001;
    end
    // output stage
    next_q.out_a = pin_stage(pre_a, q.enable[0], q.faulten[0], q.f_sync, q.invert[0]);
    next_q.out_b = pin_stage(pre_b, q.enable[1], q.faulten[1], q.f_sync, q.invert[1]);
    // interrupt from raw events
    next_q.irq = |(ev_vec & q.inten[5:0]) || (q.inten[`PWMDB_INT_FAULT] && q.f_sync);
    // register reads
    if (rd_en)
    begin
      case (addr)
        `PWMDB_OFS_CTL: next_q.rd_data = {29'h0000_0000, q.syncmode, q.updown, q.run};
        `PWMDB_OFS_ENABLE: next_q.rd_data = {30'h0000_0000, q.enable};
        `PWMDB_OFS_INVERT: next_q.rd_data = {30'h0000_0000, q.invert};
        `PWMDB_OFS_FAULT: next_q.rd_data = {30'h0000_0000, q.faulten};
        `PWMDB_OFS_INTEN: next_q.rd_data = {25'h000_0000, q.inten};
        `PWMDB_OFS_STATUS:
          next_q.rd_data = {27'h000_0000, q.pend, q.second_gen_output, q.first_gen_output,
                            q.dir, q.f_sync};
        `PWMDB_OFS_LOAD: next_q.rd_data = {16'h0000, q.sh_load};
        `PWMDB_OFS_COUNT: next_q.rd_data = {16'h0000, q.count};
        `PWMDB_OFS_CMPA: next_q.rd_data = {16'h0000, q.sh_cmpa};
        `PWMDB_OFS_CMPB: next_q.rd_data = {16'h0000, q.sh_cmpb};
        `PWMDB_OFS_GENA: next_q.rd_data = {20'h0_0000, q.gena};
        `PWMDB_OFS_GENB: next_q.rd_data = {20'h0_0000, q.genb};
        `PWMDB_OFS_DBCTL: next_q.rd_data = {31'h0000_0000, q.dben};
        `PWMDB_OFS_DBRISE: next_q.rd_data = {20'h0_0000, q.dbrise};
        `PWMDB_OFS_DBFALL: next_q.rd_data = {20'h0_0000, q.dbfall};
        default: next_q.rd_data = `PWMDB_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign rd_data = q.rd_data;
  assign pwm_out_a = q.out_a;
  assign pwm_out_b = q.out_b;
  assign irq = q.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence seq_down_zero;
    q.run && !q.updown && (q.count == 16'h0000) && !wr_en;
  endsequence

  sequence seq_up_step;
    q.run && q.updown && q.dir && (q.count < q.load) && !q.pend && !wr_en;
  endsequence

  chk_down_wrap: assert property (seq_down_zero and !q.pend |=> ev_load)
    else $error("load strobe did not follow zero in count-down");
  chk_up_step: assert property (seq_up_step |=> (q.count == $past(q.count) + 16'h0001))
    else $error("up count did not increment");
  chk_dir_low: assert property (q.run && !q.updown |=> !q.dir)
    else $error("direction high in count-down");
  chk_cmp_range: assert property ((q.cmpa > q.load) |-> !match_a)
    else $error("compare above load matched");
  chk_match_ignored: assert property ((ev_zero || ev_load) |-> !(|ev_vec[5:2]))
    else $error("match event beside zero or load");
  chk_db_overlap: assert property (q.dben && q.da |-> !q.db)
    else $error("dead-band outputs both high");
  chk_fault_force: assert property (q.f_sync && q.faulten[0] && q.enable[0]
                                    |=> (pwm_out_a == $past(q.invert[0])))
    else $error("fault did not force output inactive");
  chk_irq_event: assert property (|(ev_vec & q.inten[5:0]) |=> irq)
    else $error("enabled event raised no interrupt");
  chk_update_zero: assert property (q.pend && (q.count == 16'h0000)
                                    |=> (q.load == $past(q.sh_load)))
    else $error("pending load not applied at zero");
  chk_db_bypass: assert property (!q.dben && q.enable[0] && !q.faulten[0] && !q.invert[0]
                                  |=> (pwm_out_a == $past(q.first_gen_output)))
    else $error("bypass did not pass signal one");

  // strobe width and interrupt source
  chk_zero_pulse: assert property (ev_zero && (q.load != 16'h0000) && !q.pend
                                   |=> !ev_zero)
    else $error("zero strobe longer than one cycle");
  chk_load_pulse: assert property (ev_load && (q.load != 16'h0000) && !q.pend && !wr_en
                                   |=> !ev_load)
    else $error("load strobe longer than one cycle");
  chk_irq_quiet: assert property (!(|(ev_vec & q.inten[5:0]))
                                  && !(q.inten[`PWMDB_INT_FAULT] && q.f_sync) |=> !irq)
    else $error("interrupt without an enabled event");

  // tie handling and dead-band delays
  chk_tie_first: assert property (ev_adn && ev_bdn
                                  && (q.gena[`PWMDB_GEN_ADN +: 2] == PWMDB_ACT_HIGH)
                                  |=> q.first_gen_output)
    else $error("tie did not use the A action on signal one");
  chk_tie_second: assert property (ev_adn && ev_bdn
                                   && (q.genb[`PWMDB_GEN_BDN +: 2] == PWMDB_ACT_LOW)
                                   |=> !q.second_gen_output)
    else $error("tie did not use the B action on signal two");
  chk_db_rise: assert property (q.first_gen_output && !q.da && (q.rcnt < q.dbrise)
                                |=> !q.da)
    else $error("dead-band rise before its delay");
  chk_db_fall: assert property (!q.first_gen_output && !q.db && (q.fcnt < q.dbfall)
                                |=> !q.db)
    else $error("dead-band inverse rose before its delay");
endmodule
`default_nettype wire

// *** test/pwmdb_bridge.sv ***
`timescale 1ns/1ns
`default_nettype none
// half-bridge power stage: watches both legs, drives the fault line
module pwmdb_bridge
(
  input wire logic clock,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic trip,
  output logic fault_in,
  output logic [15:0] shoot_cnt
);
  initial
  begin
    fault_in = 1'b0;
    shoot_cnt = 16'h0000;
  end
  always @(posedge clock)
  begin
    // fault line follows the trip command one edge later
    fault_in <= trip;
    // count cycles with both legs on
    if (pwm_out_a === 1'b1 && pwm_out_b === 1'b1)
    begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pwmdb_map.svh"
module testbench;
  import pwmdb_pkg::*;
  logic clock;
  logic sys_rst;
  pwmdb_addr_t addr;
  pwmdb_data_t wr_data;
  logic wr_en;
  logic rd_en;
  pwmdb_data_t rd_data;
  logic fault_in;
  logic pwm_out_a;
  logic pwm_out_b;
  logic irq;
  logic trip;
  logic [15:0] shoot_cnt;
  logic [15:0] s0;
  int fail_count;
  int checks;
  int na;
  int nb;
  int g1;
  int g2;

  pwmdb_gen dut (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fault_in(fault_in),
    .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .irq(irq));
  pwmdb_bridge stage (.clock(clock), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .trip(trip), .fault_in(fault_in), .shoot_cnt(shoot_cnt));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input pwmdb_addr_t a, input pwmdb_data_t d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input pwmdb_addr_t a, input pwmdb_data_t exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask

  // cycles from one interrupt pulse to the next, 60 when none comes
  task automatic gap_of(input bit first, output int n);
    int t;
    t = 0;
    if (first)
    begin
      do
      begin
        @(posedge clock);
        #1;
        t++;
      end while (irq !== 1'b1 && t < 60);
    end
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 60);
  endtask

  // high cycles of each pin over two periods of ten
  task automatic highs();
    na = 0;
    nb = 0;
    repeat (12) @(posedge clock);
    repeat (20)
    begin
      @(posedge clock);
      #1;
      na += (pwm_out_a === 1'b1);
      nb += (pwm_out_b === 1'b1);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clock);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    trip = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    check({pwm_out_a, pwm_out_b, irq}, 32'h0000_0000);
    rd(`PWMDB_OFS_COUNT, 32'h0000_0000);
    rd(`PWMDB_OFS_STATUS, 32'h0000_0000);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_0000);
    wr(`PWMDB_OFS_LOAD, 32'h0001_2345);
    rd(`PWMDB_OFS_LOAD, 32'h0000_2345);
    // down mode, period ten, compare A at four
    wr(`PWMDB_OFS_LOAD, 32'h0000_0009);
    wr(`PWMDB_OFS_CMPA, 32'h0000_0004);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0001);
    wr(`PWMDB_OFS_CTL, 32'h0000_0001);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_000A);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0002);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_000A);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0003);
    gap_of(1'b1, g1);
    gap_of(1'b0, g2);
    check(g1 + g2, 32'h0000_000A);
    check(g1 * g2, 32'h0000_0009);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0008);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_000A);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0004);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_003C);
    wr(`PWMDB_OFS_CMPA, 32'h0000_000A);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0008);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_003C);
    wr(`PWMDB_OFS_CMPA, 32'h0000_0004);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0000);
    // output a: high at zero, low at A down; output b toggles at zero
    wr(`PWMDB_OFS_GENA, 32'h0000_0083);
    wr(`PWMDB_OFS_GENB, 32'h0000_0001);
    wr(`PWMDB_OFS_ENABLE, 32'h0000_0003);
    highs();
    check(na, 32'h0000_000C);
    check(nb, 32'h0000_000A);
    wr(`PWMDB_OFS_INVERT, 32'h0000_0001);
    highs();
    check(na, 32'h0000_0008);
    wr(`PWMDB_OFS_FAULT, 32'h0000_0001);
    trip <= 1'b1;
    highs();
    check(na, 32'h0000_0014);
    check(nb, 32'h0000_000A);
    wr(`PWMDB_OFS_INVERT, 32'h0000_0000);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0040);
    highs();
    check(na, 32'h0000_0000);
    check(irq, 32'h0000_0001);
    trip <= 1'b0;
    wr(`PWMDB_OFS_FAULT, 32'h0000_0000);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0000);
    wr(`PWMDB_OFS_ENABLE, 32'h0000_0002);
    highs();
    check(na, 32'h0000_0000);
    check(nb, 32'h0000_000A);
    // complementary pair with dead band
    wr(`PWMDB_OFS_ENABLE, 32'h0000_0003);
    wr(`PWMDB_OFS_DBRISE, 32'h0000_0001);
    wr(`PWMDB_OFS_DBFALL, 32'h0000_0001);
    wr(`PWMDB_OFS_DBCTL, 32'h0000_0001);
    repeat (12) @(posedge clock);
    s0 = shoot_cnt;
    highs();
    check(na > 0 && na < 12, 32'h0000_0001);
    check(nb > 0 && nb < 8, 32'h0000_0001);
    check(shoot_cnt, s0);
    // A match at zero is ignored
    wr(`PWMDB_OFS_DBCTL, 32'h0000_0000);
    wr(`PWMDB_OFS_GENA, 32'h0000_0040);
    wr(`PWMDB_OFS_CMPA, 32'h0000_0000);
    highs();
    check(na % 20, 32'h0000_0000);
    // coinciding matches: each signal takes its own comparator's action
    wr(`PWMDB_OFS_CMPA, 32'h0000_0004);
    wr(`PWMDB_OFS_CMPB, 32'h0000_0004);
    wr(`PWMDB_OFS_GENA, 32'h0000_08C2);
    wr(`PWMDB_OFS_GENB, 32'h0000_08C3);
    highs();
    check(na, 32'h0000_0008);
    check(nb, 32'h0000_000C);
    // up/down triangle
    wr(`PWMDB_OFS_CMPA, 32'h0000_0004);
    wr(`PWMDB_OFS_CTL, 32'h0000_0003);
    wr(`PWMDB_OFS_INTEN, 32'h0000_0001);
    gap_of(1'b1, g1);
    check(g1, 32'h0000_0012);
    wr(`PWMDB_OFS_INTEN, 32'h0000_000C);
    gap_of(1'b1, g1);
    gap_of(1'b0, g2);
    check(g1 + g2, 32'h0000_0012);
    check(g1 * g2, 32'h0000_0050);
    // synchronous update waits for the global update
    wr(`PWMDB_OFS_INTEN, 32'h0000_0001);
    wr(`PWMDB_OFS_CTL, 32'h0000_0007);
    wr(`PWMDB_OFS_LOAD, 32'h0000_0005);
    gap_of(1'b1, g1);
    gap_of(1'b0, g1);
    check(g1, 32'h0000_0012);
    wr(`PWMDB_OFS_CTL, 32'h0000_000F);
    gap_of(1'b1, g1);
    gap_of(1'b0, g1);
    check(g1, 32'h0000_000A);
    end_of_test();
  end
endmodule
`default_nettype wire
